/* File: pkg/spdif_in_pkg.sv */
// Constants and types shared by the serial audio input port of the S/PDIF transmitter.
package spdif_in_pkg;

	// Register byte offsets on the AHB-Lite slave.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] LEFT_OFS = 8'h08;
	localparam logic [7:0] RIGHT_OFS = 8'h0C;

	// Control register field positions.
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_FMT_LSB = 1;
	localparam int CTRL_WID_LSB = 3;
	localparam int CTRL_OSR_BIT = 5;

	// Status register field positions.
	localparam int STAT_PAIR_BIT = 0;
	localparam int STAT_FS_BIT = 1;
	localparam int STAT_HALF_BIT = 2;
	localparam int STAT_CNT_LSB = 16;

	// Justification formats.
	typedef enum logic [1:0] {
		FMT_I2S = 2'h0,
		FMT_LJ = 2'h1,
		FMT_RJ = 2'h2
	} fmt_t;

	// Sample word widths.
	typedef enum logic [1:0] {
		WID_16 = 2'h0,
		WID_18 = 2'h1,
		WID_20 = 2'h2,
		WID_24 = 2'h3
	} wid_t;

	// Values after reset: I2S, 24-bit words, 256x oversampling, enabled.
	localparam logic CTRL_EN_RST = 1'b1;
	localparam fmt_t CTRL_FMT_RST = FMT_I2S;
	localparam wid_t CTRL_WID_RST = WID_24;
	localparam logic CTRL_OSR_RST = 1'b0;

	// Framing figures.
	localparam int WORD_MAX = 24;
	localparam int SLOT_BITS = 32;
	localparam logic [5:0] IDX_MAX = 6'h3F;
	localparam logic [4:0] I2S_DELAY = 5'h01;

	// Oversampling ratios and the biphase cell rate, all per frame.
	localparam int OSR_LO = 256;
	localparam int OSR_HI = 384;
	localparam int BIPHASE_PER_FRAME = 128;
	localparam logic [1:0] DIV_LO_LAST = 2'(OSR_LO / BIPHASE_PER_FRAME - 1);
	localparam logic [1:0] DIV_HI_LAST = 2'(OSR_HI / BIPHASE_PER_FRAME - 1);

endpackage : spdif_in_pkg

/* File: src/pin_sync.sv */
// Two-stage synchroniser for a group of asynchronous input pins.
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins and synchronised levels
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_out
);

	logic [WIDTH-1:0] meta_q;

	// A group of no pins cannot be built, so elaboration stops here.
	if (WIDTH < 1) begin : g_width_check
		$error("pin_sync: WIDTH must be at least 1");
	end

	// The first stage is read by the second stage only.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			pin_sync_out <= '0;
		end else begin
			meta_q <= pin_in;
			pin_sync_out <= meta_q;
		end
	end

endmodule : pin_sync

/* File: src/spdif_serial_in.sv */
// Serial audio input port and biphase clock divider of the S/PDIF transmitter.
//
// Operation
// - Serial data must be stable at the bit clock rising edge and is sampled on that edge.
// - In right- and left-justified formats frame sync high marks left and low marks right.
// - In I2S format, the reset default, frame sync low marks left and high marks right.
// - In right-justified format the MSB is taken 12 bit clocks after a transition for 20-bit words and 16 for 16-bit words.
// - In I2S format the MSB is taken exactly one bit clock after each frame sync transition.
// - In left-justified format the MSB is taken on the first sampling edge after a transition.
// - The biphase clock is made by dividing down the oversampling clock.
// - The oversampling clock runs at 384 or 256 times the frame rate and the divider serves both.
// - Word widths of 16, 18, 20 and 24 bits are accepted in all three formats.
`timescale 1ns/1ns
module spdif_serial_in (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA,
	// Serial audio pins from the signal routing unit
	input wire logic BIT_CLOCK,
	input wire logic FRAME_SYNC,
	input wire logic SERIAL_DATA_IN,
	input wire logic OVERSAMPLE_CLOCK,
	// Sample pair towards the encoder
	output logic [spdif_in_pkg::WORD_MAX-1:0] LEFT_WORD,
	output logic [spdif_in_pkg::WORD_MAX-1:0] RIGHT_WORD,
	output logic WORD_VALID,
	// Biphase clock enable towards the encoder
	output logic BIPHASE_CLK_EN
);

	import spdif_in_pkg::*;

	// Pins pass two flip-flops; the reference clock must be well above twice
	// the bit and oversampling clock rates, or edges are missed.
	logic [3:0] pin_s;
	logic bclk_s;
	logic fs_s;
	logic sd_s;
	logic osc_s;
	logic bclk_prev_q;
	logic osc_prev_q;
	logic bclk_rise;
	logic osc_rise;

	pin_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.pin_in({OVERSAMPLE_CLOCK, SERIAL_DATA_IN, FRAME_SYNC, BIT_CLOCK}),
		.pin_sync_out(pin_s)
	);

	assign bclk_s = pin_s[0];
	assign fs_s = pin_s[1];
	assign sd_s = pin_s[2];
	assign osc_s = pin_s[3];

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bclk_prev_q <= 1'b0;
			osc_prev_q <= 1'b0;
		end else begin
			bclk_prev_q <= bclk_s;
			osc_prev_q <= osc_s;
		end
	end

	assign bclk_rise = bclk_s & ~bclk_prev_q;
	assign osc_rise = osc_s & ~osc_prev_q;

	// Control register.
	logic ctrl_en_q;
	fmt_t ctrl_fmt_q;
	wid_t ctrl_wid_q;
	logic ctrl_osr_q;

	// Bus data phase bookkeeping.
	logic dp_wr_q;
	logic dp_rd_q;
	logic [7:0] dp_addr_q;
	logic dp_hit_q;
	logic addr_phase;
	logic ctrl_wr;
	logic stat_wr;

	assign addr_phase = HSEL & HTRANS[1] & HREADY;
	assign ctrl_wr = dp_wr_q & dp_hit_q & (dp_addr_q == CTRL_OFS);
	assign stat_wr = dp_wr_q & dp_hit_q & (dp_addr_q == STATUS_OFS);

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_en_q <= CTRL_EN_RST;
			ctrl_fmt_q <= CTRL_FMT_RST;
			ctrl_wid_q <= CTRL_WID_RST;
			ctrl_osr_q <= CTRL_OSR_RST;
		end else if (ctrl_wr) begin
			ctrl_en_q <= HWDATA[CTRL_EN_BIT];
			ctrl_wid_q <= wid_t'(HWDATA[CTRL_WID_LSB +: 2]);
			ctrl_osr_q <= HWDATA[CTRL_OSR_BIT];
			// An unused format code is refused and the old format stays.
			if (HWDATA[CTRL_FMT_LSB +: 2] != 2'h3) begin
				ctrl_fmt_q <= fmt_t'(HWDATA[CTRL_FMT_LSB +: 2]);
			end
		end
	end

	// Framing derived from the control register.
	logic [4:0] wid_bits;
	logic [5:0] start_idx;
	logic left_level;

	always_comb begin
		unique case (ctrl_wid_q)
			WID_16: wid_bits = 5'h10;
			WID_18: wid_bits = 5'h12;
			WID_20: wid_bits = 5'h14;
			WID_24: wid_bits = 5'h18;
		endcase
	end

	always_comb begin
		unique case (ctrl_fmt_q)
			FMT_LJ: start_idx = 6'h00;
			FMT_RJ: start_idx = 6'(SLOT_BITS) - {1'b0, wid_bits};
			default: start_idx = {1'b0, I2S_DELAY};
		endcase
	end

	// Level of frame sync that marks the left channel.
	assign left_level = (ctrl_fmt_q == FMT_I2S) ? 1'b0 : 1'b1;

	// Bit counter, advanced on each bit clock rising edge up to IDX_MAX, and shift register, advanced on those rising edges that fall inside the word.
	logic fs_smp_q;
	logic seen_q;
	logic word_ok_q;
	logic [5:0] bit_idx_q;
	logic [5:0] cur_idx;
	logic [WORD_MAX-1:0] shift_q;
	logic fs_edge;
	logic take;
	logic [WORD_MAX-1:0] aligned;

	assign fs_edge = bclk_rise & seen_q & (fs_s != fs_smp_q);
	assign cur_idx = fs_edge ? 6'h00 : bit_idx_q;
	assign take = bclk_rise & (cur_idx >= start_idx) & (cur_idx < start_idx + {1'b0, wid_bits});
	// Words leave left-aligned in 24 bits, the unused low bits zero.
	assign aligned = shift_q << (5'(WORD_MAX) - wid_bits);

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			fs_smp_q <= 1'b0;
			seen_q <= 1'b0;
		end else if (!ctrl_en_q) begin
			seen_q <= 1'b0;
		end else if (bclk_rise) begin
			fs_smp_q <= fs_s;
			seen_q <= 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bit_idx_q <= 6'h00;
		end else if (fs_edge) begin
			bit_idx_q <= 6'h01;
		end else if (bclk_rise && bit_idx_q != IDX_MAX) begin
			bit_idx_q <= bit_idx_q + 6'h01;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			shift_q <= '0;
		end else if (fs_edge) begin
			shift_q <= take ? {{(WORD_MAX-1){1'b0}}, sd_s} : '0;
		end else if (take) begin
			shift_q <= {shift_q[WORD_MAX-2:0], sd_s};
		end
	end

	// The first word after enabling starts mid-frame and is thrown away.
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			word_ok_q <= 1'b0;
		end else if (!ctrl_en_q) begin
			word_ok_q <= 1'b0;
		end else if (fs_edge) begin
			word_ok_q <= 1'b1;
		end
	end

	// Channel holding registers and pair hand-over.
	logic [WORD_MAX-1:0] left_hold_q;
	logic have_left_q;
	logic left_done;
	logic right_done;
	logic pair_done;

	assign left_done = fs_edge & word_ok_q & (fs_smp_q == left_level);
	assign right_done = fs_edge & word_ok_q & (fs_smp_q != left_level);
	assign pair_done = right_done & have_left_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			left_hold_q <= '0;
			have_left_q <= 1'b0;
		end else if (!ctrl_en_q) begin
			have_left_q <= 1'b0;
		end else if (left_done) begin
			left_hold_q <= aligned;
			have_left_q <= 1'b1;
		end else if (right_done) begin
			have_left_q <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LEFT_WORD <= '0;
			RIGHT_WORD <= '0;
			WORD_VALID <= 1'b0;
		end else begin
			WORD_VALID <= pair_done;
			if (pair_done) begin
				LEFT_WORD <= left_hold_q;
				RIGHT_WORD <= aligned;
			end
		end
	end

	// Biphase divider: 128 enable pulses per frame at either ratio.
	logic [1:0] div_cnt_q;
	logic [1:0] div_last;

	assign div_last = ctrl_osr_q ? DIV_HI_LAST : DIV_LO_LAST;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			div_cnt_q <= 2'h0;
			BIPHASE_CLK_EN <= 1'b0;
		end else begin
			BIPHASE_CLK_EN <= 1'b0;
			if (osc_rise) begin
				if (div_cnt_q >= div_last) begin
					div_cnt_q <= 2'h0;
					BIPHASE_CLK_EN <= 1'b1;
				end else begin
					div_cnt_q <= div_cnt_q + 2'h1;
				end
			end
		end
	end

	// Status: sticky pair flag (write one to clear, a new pair wins) and a pair counter.
	logic pair_flag_q;
	logic [15:0] pair_cnt_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pair_flag_q <= 1'b0;
		end else if (pair_done) begin
			pair_flag_q <= 1'b1;
		end else if (stat_wr && HWDATA[STAT_PAIR_BIT]) begin
			pair_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pair_cnt_q <= 16'h0000;
		end else if (pair_done) begin
			pair_cnt_q <= pair_cnt_q + 16'h0001;
		end
	end

	// Bus slave: writes finish with no wait, reads take one wait state so a
	// read straight after a write already sees the written value.
	logic [31:0] rd_mux;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dp_wr_q <= 1'b0;
			dp_rd_q <= 1'b0;
			dp_addr_q <= 8'h00;
			dp_hit_q <= 1'b0;
		end else begin
			if (HREADYOUT) begin
				dp_wr_q <= addr_phase & HWRITE;
				dp_rd_q <= addr_phase & ~HWRITE;
				if (addr_phase) begin
					dp_addr_q <= HADDR[7:0];
					dp_hit_q <= (HADDR[31:4] == 28'h0000000);
				end
			end else begin
				dp_rd_q <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		if (dp_hit_q) begin
			unique case (dp_addr_q)
				CTRL_OFS: begin
					rd_mux[CTRL_EN_BIT] = ctrl_en_q;
					rd_mux[CTRL_FMT_LSB +: 2] = ctrl_fmt_q;
					rd_mux[CTRL_WID_LSB +: 2] = ctrl_wid_q;
					rd_mux[CTRL_OSR_BIT] = ctrl_osr_q;
				end
				STATUS_OFS: begin
					rd_mux[STAT_PAIR_BIT] = pair_flag_q;
					rd_mux[STAT_FS_BIT] = fs_smp_q;
					rd_mux[STAT_HALF_BIT] = have_left_q;
					rd_mux[STAT_CNT_LSB +: 16] = pair_cnt_q;
				end
				LEFT_OFS: rd_mux[WORD_MAX-1:0] = LEFT_WORD;
				RIGHT_OFS: rd_mux[WORD_MAX-1:0] = RIGHT_WORD;
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA <= 32'h00000000;
		end else if (dp_rd_q) begin
			HRDATA <= rd_mux;
		end
	end

	assign HREADYOUT = ~dp_rd_q;
	assign HRESP = 1'b0;

endmodule : spdif_serial_in

/* File: test/spdif_in_props.sv */
// Concurrent checks on the bus and output pins of the serial input port.
`timescale 1ns/1ns
module spdif_in_props (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Register bus
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic [31:0] HRDATA,
	// Encoder side
	input wire logic [spdif_in_pkg::WORD_MAX-1:0] LEFT_WORD,
	input wire logic [spdif_in_pkg::WORD_MAX-1:0] RIGHT_WORD,
	input wire logic WORD_VALID,
	input wire logic BIPHASE_CLK_EN
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	wire logic rd_go = HSEL && HTRANS[1] && !HWRITE && HREADY;
	a_resp_okay: assert property (HRESP == 1'b0) else $error("bad response");
	a_read_wait: assert property (rd_go |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait wrong");
	a_write_nowait: assert property (HSEL && HTRANS[1] && HWRITE && HREADY |=> HREADYOUT)
		else $error("write stalled");
	a_wait_cause: assert property (!HREADYOUT |-> $past(rd_go))
		else $error("stray wait");
	a_rdata_hold: assert property ($changed(HRDATA) |-> $past(rd_go) || $past(rd_go, 2))
		else $error("read data moved");
	a_pair_spaced: assert property (WORD_VALID |=> !WORD_VALID [*8])
		else $error("pair pulse too close");
	a_words_hold: assert property (!WORD_VALID |-> $stable(LEFT_WORD) && $stable(RIGHT_WORD))
		else $error("words moved alone");
	a_biphase_spaced: assert property (BIPHASE_CLK_EN |=> !BIPHASE_CLK_EN [*8])
		else $error("biphase pulse too close");
	c_read: cover property (rd_go);
	c_pair: cover property (WORD_VALID);
	c_biphase: cover property (BIPHASE_CLK_EN);
endmodule : spdif_in_props

/* File: test/audio_source.sv */
// Behavioural serial audio source driving the port's pins.
`timescale 1ns/1ns
module audio_source #(
	parameter int HALF_NS = 170
) (
	// Framing chosen by the bench
	input wire logic [1:0] fmt,
	input wire logic [4:0] width,
	input wire logic [23:0] left_smp,
	input wire logic [23:0] right_smp,
	// Pins as delivered through the routing unit.
	output logic bclk,
	output logic fsync,
	output logic serial_data_in,
	output logic osclk
);
	import spdif_in_pkg::*;
	int start;
	logic [23:0] smp;
	// An odd period keeps the oversampling clock unrelated to the bit clock.
	initial begin
		osclk = 1'b0;
		forever #(HALF_NS + 7) osclk = ~osclk;
	end
	// Lines change on the falling edge so they are steady at the sampling edge.
	initial begin
		{bclk, fsync, serial_data_in} = 3'h0;
		forever begin
			for (int i = 0; i < 64; i++) begin
				start = fmt == FMT_LJ ? 0 : fmt == FMT_I2S ? 1 : 32 - int'(width);
				fsync = (fmt == FMT_I2S) == (i >= 32);
				smp = i < 32 ? left_smp : right_smp;
				if (i % 32 >= start && i % 32 < start + int'(width))
					serial_data_in = smp[start + int'(width) - 1 - i % 32];
				else
					serial_data_in = ~serial_data_in;
				#HALF_NS bclk = 1'b1;
				#HALF_NS bclk = 1'b0;
			end
		end
	end
endmodule : audio_source

/* File: test/spdif_serial_in_tb.sv */
// Self-checking bench for the serial audio input port.
`timescale 1ns/1ns
module spdif_serial_in_tb;
	import spdif_in_pkg::*;
	logic ref_clk, rst_n, hsel, hwrite, hrdy, hresp, valid, bp_en, bclk, fsync, serial_data_in, osclk;
	logic [1:0] htrans, fmt;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [23:0] left_w, right_w, l_smp, r_smp;
	logic [4:0] wid_bits;
	int seed = 32'h0D67;
	int n_mismatch = 0, total_checks = 0, cycles = 0, n_os = 0, n_bp = 0;
	int wbits[4] = '{16, 18, 20, 24};
	spdif_serial_in i_spdif_serial_in (.REF_CLK(ref_clk), .RST_N(rst_n), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hrdy), .HREADYOUT(hrdy), .HRESP(hresp), .HRDATA(hrdata), .BIT_CLOCK(bclk),
		.FRAME_SYNC(fsync), .SERIAL_DATA_IN(serial_data_in), .OVERSAMPLE_CLOCK(osclk),
		.LEFT_WORD(left_w), .RIGHT_WORD(right_w), .WORD_VALID(valid), .BIPHASE_CLK_EN(bp_en));
	audio_source i_audio_source (.fmt(fmt), .width(wid_bits), .left_smp(l_smp),
		.right_smp(r_smp), .bclk(bclk), .fsync(fsync), .serial_data_in(serial_data_in), .osclk(osclk));
	function automatic logic [31:0] ctrl(logic [1:0] f, logic [1:0] w, logic o);
		return 32'(o) << CTRL_OSR_BIT | 32'(w) << CTRL_WID_LSB | 32'(f) << CTRL_FMT_LSB
			| 32'h1 << CTRL_EN_BIT;
	endfunction : ctrl
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic ahb(logic wr, logic [31:0] a, logic [31:0] wd, output logic [31:0] d);
		logic r;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		do begin
			@(negedge ref_clk);
			r = hrdy;
			@(posedge ref_clk);
		end while (r !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(negedge ref_clk);
			r = hrdy;
			d = hrdata;
			@(posedge ref_clk);
		end while (r !== 1'b1);
	endtask : ahb
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge osclk) n_os++;
	// A hang in any wait below ends here rather than running on.
	always @(posedge ref_clk) begin
		cycles++;
		if (bp_en === 1'b1)
			n_bp++;
		if (cycles == 60000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		fmt_t f;
		int w, d;
		{hsel, hwrite, htrans, haddr, hwdata, fmt, wid_bits, l_smp, r_smp} = '0;
		rst_n = 1'b0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		ahb(1'b0, 32'(CTRL_OFS), 32'h0, rd);
		chk(rd, ctrl(FMT_I2S, WID_24, 1'b0));
		ahb(1'b0, 32'h10, 32'h0, rd);
		chk(rd, 32'h0);
		for (int c = 0; c < 12; c++) begin
			f = fmt_t'(c % 3);
			w = wbits[c / 3];
			d = c[0] ? 3 : 2;
			ahb(1'b1, 32'(CTRL_OFS), ctrl(f, 2'(c / 3), c[0]), rd);
			ahb(1'b0, 32'(CTRL_OFS), 32'h0, rd);
			chk(rd, ctrl(f, 2'(c / 3), c[0]));
			fmt <= f;
			wid_bits <= 5'(w);
			l_smp <= 24'($random(seed)) >> (24 - w);
			r_smp <= 24'($random(seed)) >> (24 - w);
			n_os = 0;
			n_bp = 0;
			// Early pairs may straddle the change of framing, so only the fourth counts.
			// Outputs are looked at mid-cycle, well clear of the edge that moves them.
			repeat (4) @(negedge ref_clk iff valid === 1'b1);
			chk(32'(left_w), 32'(l_smp << (24 - w)));
			chk(32'(right_w), 32'(r_smp << (24 - w)));
			chk(32'(n_bp * d >= n_os - 4 && n_bp * d <= n_os + 4), 32'h1);
			@(posedge ref_clk);
		end
		ahb(1'b0, 32'(LEFT_OFS), 32'h0, rd);
		chk(rd, 32'(l_smp << (24 - w)));
		ahb(1'b0, 32'(RIGHT_OFS), 32'h0, rd);
		chk(rd, 32'(r_smp << (24 - w)));
		ahb(1'b0, 32'(STATUS_OFS), 32'h0, rd);
		chk(32'(rd[STAT_PAIR_BIT]), 32'h1);
		// Format code 3 is refused while the other fields of the word still land.
		ahb(1'b1, 32'(CTRL_OFS), 32'h00000007, rd);
		ahb(1'b0, 32'(CTRL_OFS), 32'h0, rd);
		chk(rd, ctrl(FMT_RJ, 2'h0, 1'b0));
		// Disabled, the port must neither finish a pair nor hold a half pair.
		ahb(1'b1, 32'(CTRL_OFS), 32'h0, rd);
		ahb(1'b1, 32'(STATUS_OFS), 32'h1, rd);
		ahb(1'b0, 32'(STATUS_OFS), 32'h0, rd);
		chk(32'(rd[STAT_PAIR_BIT]), 32'h0);
		chk(32'(rd[STAT_HALF_BIT]), 32'h0);
		w = int'(rd[STAT_CNT_LSB +: 16]);
		repeat (1200) @(posedge ref_clk);
		ahb(1'b0, 32'(STATUS_OFS), 32'h0, rd);
		chk(32'(rd[STAT_CNT_LSB +: 16]), 32'(w));
		end_sim();
	end
endmodule : spdif_serial_in_tb
bind spdif_serial_in spdif_in_props i_spdif_in_props (.REF_CLK(REF_CLK), .RST_N(RST_N),
	.HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
	.HRESP(HRESP), .HRDATA(HRDATA), .LEFT_WORD(LEFT_WORD), .RIGHT_WORD(RIGHT_WORD),
	.WORD_VALID(WORD_VALID), .BIPHASE_CLK_EN(BIPHASE_CLK_EN));
